// ---- rtl/rail_setpoint_pkg.sv ----
// Constants shared by the rail setpoint and slew control register bank.
`default_nettype none
package rail_setpoint_pkg;
   // Register offsets on the internal register port.
   localparam logic [7:0] buck_boost_addr = 8'h19;
   localparam logic [7:0] slew_addr = 8'h1a;
   localparam logic [7:0] linear_addr = 8'h1b;
   localparam logic [7:0] first_buck_addr = 8'h10;
   localparam logic [7:0] second_buck_addr = 8'h11;
   // Field positions.
   localparam int trigger_bit = 7;
   localparam int auto_apply_bit = 6;
   localparam int slew_lsb = 0;
   localparam int setpoint_lsb = 0;
   localparam int pulse_skip_bit = 7;
   // Reset values and the immediate slew code.
   localparam logic [2:0] slew_reset = 3'h6;
   localparam logic [5:0] linear_reset = 6'h1f;
   localparam logic [5:0] buck_boost_reset = 6'h32;
   localparam logic [5:0] buck_reset = 6'h0a;
   localparam logic [2:0] slew_immediate = 3'h7;
   // Buck-boost rail code limits.
   localparam logic [5:0] buck_boost_max_code = 6'h34;
   // Timing.
   localparam int clk_mhz = 50;
   localparam int step_base_ns = 2500;
   localparam int step_base_cycles = step_base_ns * clk_mhz / 1000;
   localparam int blank_ms = 5;
   localparam int blank_cycles_default = blank_ms * 1000 * clk_mhz * 1000 / 1000;
endpackage
`default_nettype wire

// ---- rtl/rail_setpoint_slew_control.sv ----
// Setpoint registers, buck slew sequencer and linear regulator monitor blanking.
//////////////////////////////////////////////////////////////////////////////
// How it works
// - Buck-boost codes 24h..34h give 2.600 V..3.400 V in 50 mV steps; writes of reserved codes 35h..3Fh are ignored.
// - Slew rate and trigger act only on the first and second scaled bucks.
// - Writing 1 to slew bit 7 starts moving both bucks to their stored targets; writing 0 does nothing.
// - The trigger bit clears itself when the transition ends and resets to 0.
// - With auto-apply disable (bit 6) set, a buck setpoint write starts the transition by itself.
// - Slew field bits 2-0 reset to 6h; codes 0..6 give 160,80,40,20,10,5,2.5 us per step.
// - Slew code 7h applies the target at once with no timed stepping.
// - The linear regulator register only accepts writes while the password unlock is present.
// - Each accepted linear regulator write blanks its voltage monitor for 5 ms.
// - Linear field bits 5-0 reset to 1Fh; bits 7-6 read zero.
// - Buck-boost field bits 5-0 reset to 32h.
//////////////////////////////////////////////////////////////////////////////
`default_nettype none
module rail_setpoint_slew_control
   import rail_setpoint_pkg::*;
#(
   parameter int blank_cycles = blank_cycles_default
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic password_unlocked,
   output logic [7:0] reg_rdata,
   output logic [5:0] first_scaled_buck_active,
   output logic [5:0] second_scaled_buck_active,
   output logic [5:0] buck_boost_rail_setpoint,
   output logic [5:0] linear_regulator_rail_setpoint,
   output logic pulse_skip_enable_first,
   output logic pulse_skip_enable_second,
   output logic transition_busy,
   output logic linear_monitor_blank
);

   logic [5:0] first_target_r;
   logic [5:0] second_target_r;
   logic [5:0] first_active_r;
   logic [5:0] second_active_r;
   logic [5:0] buck_boost_r;
   logic [5:0] linear_r;
   logic pulse_skip_first_r;
   logic pulse_skip_second_r;
   logic trigger_r;
   logic auto_apply_disable_r;
   logic [2:0] slew_r;
   logic [22:0] step_cnt_r;
   logic [22:0] blank_cnt_r;
   logic blank_r;
   logic [7:0] rdata_r;
   logic start;
   logic done;
   logic step_tick;
   logic [22:0] step_len;

   //////////////////////////////////////////////////////////////////////////////
   // Decoded writes.
   wire wr_slew = reg_wr && reg_addr == slew_addr;
   wire wr_first = reg_wr && reg_addr == first_buck_addr;
   wire wr_second = reg_wr && reg_addr == second_buck_addr;
   wire wr_linear = reg_wr && reg_addr == linear_addr && password_unlocked;
   wire wr_bb = reg_wr && reg_addr == buck_boost_addr;

   assign start = (wr_slew && reg_wdata[trigger_bit]) ||
                  (auto_apply_disable_r && (wr_first || wr_second));
   assign done = first_active_r == first_target_r && second_active_r == second_target_r;
   // step interval; each code halves the time from 160 us down to 2.5 us.
   assign step_len = 23'(step_base_cycles << (3'h6 - slew_r));
   assign step_tick = step_cnt_r >= step_len - 23'd1;

   // Buck target registers with pulse-skip bits; these are host-facing copies.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         first_target_r <= buck_reset;
         second_target_r <= buck_reset;
         pulse_skip_first_r <= 1'b1;
         pulse_skip_second_r <= 1'b1;
      end else begin
         if (wr_first) begin
            first_target_r <= reg_wdata[setpoint_lsb +: 6];
            pulse_skip_first_r <= reg_wdata[pulse_skip_bit];
         end
         if (wr_second) begin
            second_target_r <= reg_wdata[setpoint_lsb +: 6];
            pulse_skip_second_r <= reg_wdata[pulse_skip_bit];
         end
      end
   end

   // Slew register; reserved bits 5-3 are never stored.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         auto_apply_disable_r <= 1'b0;
         slew_r <= slew_reset;
      end else if (wr_slew) begin
         auto_apply_disable_r <= reg_wdata[auto_apply_bit];
         slew_r <= reg_wdata[slew_lsb +: 3];
      end
   end

   // trigger self clear; a new start wins over completion.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         trigger_r <= 1'b0;
      end else if (start) begin
         trigger_r <= 1'b1;
      end else if (trigger_r && done) begin
         trigger_r <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst || start || !trigger_r || step_tick) begin
         step_cnt_r <= '0;
      end else begin
         step_cnt_r <= step_cnt_r + 23'd1;
      end
   end

   // only the scaled bucks move; other rails take writes directly.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         first_active_r <= buck_reset;
         second_active_r <= buck_reset;
      end else if (trigger_r && slew_r == slew_immediate) begin
         first_active_r <= first_target_r;
         second_active_r <= second_target_r;
      end else if (trigger_r && step_tick) begin
         if (first_active_r < first_target_r) first_active_r <= first_active_r + 6'd1;
         else if (first_active_r > first_target_r) first_active_r <= first_active_r - 6'd1;
         if (second_active_r < second_target_r) second_active_r <= second_active_r + 6'd1;
         else if (second_active_r > second_target_r) second_active_r <= second_active_r - 6'd1;
      end
   end

   // buck-boost rail; reserved codes are refused so the rail never leaves range.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         buck_boost_r <= buck_boost_reset;
      end else if (wr_bb && reg_wdata[5:0] <= buck_boost_max_code) begin
         buck_boost_r <= reg_wdata[setpoint_lsb +: 6];
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         linear_r <= linear_reset;
      end else if (wr_linear) begin
         linear_r <= reg_wdata[setpoint_lsb +: 6];
      end
   end

   // monitor blanking, restarted by every accepted write.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         blank_cnt_r <= '0;
      end else if (wr_linear) begin
         blank_cnt_r <= 23'(blank_cycles);
      end else if (blank_cnt_r != '0) begin
         blank_cnt_r <= blank_cnt_r - 23'd1;
      end
   end

   // registered blanking flag
   // The flag mirrors the counter's next value, so the output comes straight from a flop.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         blank_r <= 1'b0;
      end else if (wr_linear) begin
         blank_r <= 1'b1;
      end else begin
         blank_r <= blank_cnt_r > 23'h1;
      end
   end

   // Read mux, one cycle latency; unmapped offsets read zero.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         rdata_r <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            slew_addr: rdata_r <= {trigger_r, auto_apply_disable_r, 3'b000, slew_r};
            linear_addr: rdata_r <= {2'b00, linear_r};
            buck_boost_addr: rdata_r <= {2'b00, buck_boost_r};
            first_buck_addr: rdata_r <= {pulse_skip_first_r, 1'b0, first_target_r};
            second_buck_addr: rdata_r <= {pulse_skip_second_r, 1'b0, second_target_r};
            default: rdata_r <= 8'h00;
         endcase
      end
   end

   assign reg_rdata = rdata_r;
   assign first_scaled_buck_active = first_active_r;
   assign second_scaled_buck_active = second_active_r;
   assign buck_boost_rail_setpoint = buck_boost_r;
   assign linear_regulator_rail_setpoint = linear_r;
   assign pulse_skip_enable_first = pulse_skip_first_r;
   assign pulse_skip_enable_second = pulse_skip_second_r;
   assign transition_busy = trigger_r;
   assign linear_monitor_blank = blank_r;

   //////////////////////////////////////////////////////////////////////////////
   // Checks.
   property p_trigger_start;
      @(posedge clk) disable iff (sys_rst) start |=> trigger_r;
   endproperty
   a_trigger_start: assert property (p_trigger_start) else $error("trigger not set by start");
   property p_no_zero_start;
      @(posedge clk) disable iff (sys_rst) (wr_slew && !reg_wdata[trigger_bit] && !trigger_r && !wr_first && !wr_second) |=> !trigger_r;
   endproperty
   a_no_zero_start: assert property (p_no_zero_start) else $error("zero write started transition");
   property p_self_clear;
      @(posedge clk) disable iff (sys_rst) (trigger_r && done && !start) |=> !trigger_r;
   endproperty
   a_self_clear: assert property (p_self_clear) else $error("trigger did not clear");
   property p_auto_apply;
      @(posedge clk) disable iff (sys_rst) (wr_first && auto_apply_disable_r) |=> trigger_r;
   endproperty
   a_auto_apply: assert property (p_auto_apply) else $error("auto apply failed");
   property p_need_trigger;
      @(posedge clk) disable iff (sys_rst) (!trigger_r && !start) |=> $stable(first_active_r);
   endproperty
   a_need_trigger: assert property (p_need_trigger) else $error("buck moved without trigger");
   property p_immediate;
      @(posedge clk) disable iff (sys_rst) (trigger_r && slew_r == slew_immediate && !wr_first) |=> first_active_r == $past(first_target_r);
   endproperty
   a_immediate: assert property (p_immediate) else $error("immediate code did not apply");
   property p_one_code;
      @(posedge clk) disable iff (sys_rst) (trigger_r && slew_r != slew_immediate) |=> (first_active_r - $past(first_active_r) <= 6'd1 || $past(first_active_r) - first_active_r <= 6'd1);
   endproperty
   a_one_code: assert property (p_one_code) else $error("buck stepped more than one code");
   property p_locked;
      @(posedge clk) disable iff (sys_rst) (reg_wr && reg_addr == linear_addr && !password_unlocked) |=> $stable(linear_r);
   endproperty
   a_locked: assert property (p_locked) else $error("locked linear write taken");
   property p_blank;
      @(posedge clk) disable iff (sys_rst) wr_linear |=> linear_monitor_blank [*8];
   endproperty
   a_blank: assert property (p_blank) else $error("monitor not blanked");
   property p_bb_range;
      @(posedge clk) disable iff (sys_rst) 1'b1 |-> buck_boost_r <= buck_boost_max_code;
   endproperty
   a_bb_range: assert property (p_bb_range) else $error("buck-boost code reserved");
   //////////////////////////////////////////////////////////////////////////////
   // Checks on refusals, holding and readback; a broken decode would trip these.
   property p_blank_end;
      @(posedge clk) disable iff (sys_rst) (blank_cnt_r == 23'h1 && !wr_linear) |=> !linear_monitor_blank;
   endproperty
   a_blank_end: assert property (p_blank_end) else $error("blanking did not end");
   property p_trigger_hold;
      @(posedge clk) disable iff (sys_rst) (trigger_r && !done) |=> trigger_r;
   endproperty
   a_trigger_hold: assert property (p_trigger_hold) else $error("trigger cleared early");
   property p_step_wait;
      @(posedge clk) disable iff (sys_rst)
         (trigger_r && slew_r != slew_immediate && !step_tick) |=> $stable(first_active_r);
   endproperty
   a_step_wait: assert property (p_step_wait) else $error("buck stepped before interval");
   property p_bb_refused;
      @(posedge clk) disable iff (sys_rst)
         (wr_bb && reg_wdata[setpoint_lsb +: 6] > buck_boost_max_code) |=> $stable(buck_boost_r);
   endproperty
   a_bb_refused: assert property (p_bb_refused) else $error("reserved buck-boost code taken");
   property p_bb_no_slew;
      @(posedge clk) disable iff (sys_rst) !wr_bb |=> $stable(buck_boost_r);
   endproperty
   a_bb_no_slew: assert property (p_bb_no_slew) else $error("buck-boost moved without write");
   property p_slew_reserved;
      @(posedge clk) disable iff (sys_rst) (reg_rd && reg_addr == slew_addr) |=> reg_rdata[5:3] == 3'h0;
   endproperty
   a_slew_reserved: assert property (p_slew_reserved) else $error("slew reserved bits set");
   property p_rdata_hold;
      @(posedge clk) disable iff (sys_rst) !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without read");
   property p_locked_blank;
      @(posedge clk) disable iff (sys_rst)
         (reg_wr && reg_addr == linear_addr && !password_unlocked && !linear_monitor_blank) |=> !linear_monitor_blank;
   endproperty
   a_locked_blank: assert property (p_locked_blank) else $error("locked write blanked monitor");
   property p_slew_store;
      @(posedge clk) disable iff (sys_rst) wr_slew |=> slew_r == $past(reg_wdata[slew_lsb +: 3]);
   endproperty
   a_slew_store: assert property (p_slew_store) else $error("slew code not stored");
   property p_linear_read;
      @(posedge clk) disable iff (sys_rst) (reg_rd && reg_addr == linear_addr) |=> reg_rdata[7:6] == 2'h0;
   endproperty
   a_linear_read: assert property (p_linear_read) else $error("linear upper bits set");
   property p_second_step;
      @(posedge clk) disable iff (sys_rst) (trigger_r && slew_r != slew_immediate) |=>
         (second_active_r - $past(second_active_r) <= 6'h1 || $past(second_active_r) - second_active_r <= 6'h1);
   endproperty
   a_second_step: assert property (p_second_step) else $error("second buck stepped too far");
   c_trigger: cover property (@(posedge clk) disable iff (sys_rst) wr_slew && reg_wdata[trigger_bit]);
   c_auto: cover property (@(posedge clk) disable iff (sys_rst) wr_second && auto_apply_disable_r);
   c_done: cover property (@(posedge clk) disable iff (sys_rst) trigger_r && done);
   c_blank: cover property (@(posedge clk) disable iff (sys_rst) wr_linear);
   c_bb_refused: cover property (@(posedge clk) disable iff (sys_rst) wr_bb && reg_wdata[5:0] > buck_boost_max_code);

endmodule
`default_nettype wire

// ---- tb/rail_host_model.sv ----
// Host model that issues single-byte register requests.
`default_nettype none
module rail_host_model (
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic password_unlocked
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle bus at time zero.
   initial begin
      reg_wr = 1'h0;
      reg_rd = 1'h0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      password_unlocked = 1'h0;
   end
   // unlock with write
   // Unlock is held only for the request, so a stale unlock cannot leak into later writes.
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic u);
      @(posedge clk);
      reg_wr <= 1'h1;
      reg_addr <= a;
      reg_wdata <= d;
      password_unlocked <= u;
      @(posedge clk);
      reg_wr <= 1'h0;
      reg_addr <= ~a;
      reg_wdata <= ~d;
      password_unlocked <= 1'h0;
   endtask
   // Read data is sampled one cycle after the request is taken.
   task automatic rd(input logic [7:0] a, output logic [7:0] q);
      @(posedge clk);
      reg_rd <= 1'h1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'h0;
      reg_addr <= ~a;
      @(posedge clk);
      #1 q = reg_rdata;
   endtask
endmodule
`default_nettype wire

// ---- tb/rail_setpoint_slew_control_tb_top.sv ----
// Self-checking bench for the rail setpoint and slew register bank.
`default_nettype none
module rail_setpoint_slew_control_tb_top import rail_setpoint_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {logic [7:0] a; logic [7:0] d; logic u; logic [7:0] e;} row_type;
   logic clk, sys_rst, reg_wr, reg_rd, unl, ps1, ps2, busy, blank;
   logic [7:0] addr, wdata, rdata, q;
   logic [5:0] act1, act2, bb, lin;
   int bad_count, checked;
   row_type rows [7] = '{'{8'h1a, 8'h3d, 1'h0, 8'h05}, '{8'h1a, 8'h07, 1'h0, 8'h07},
      '{8'h1b, 8'hff, 1'h1, 8'h3f}, '{8'h1b, 8'h05, 1'h0, 8'h3f}, '{8'h1b, 8'h19, 1'h1, 8'h19},
      '{8'h1a, 8'h06, 1'h0, 8'h06}, '{8'h3f, 8'h55, 1'h1, 8'h00}};
   rail_setpoint_slew_control #(.blank_cycles(20)) dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(addr), .reg_wdata(wdata), .password_unlocked(unl), .reg_rdata(rdata),
      .first_scaled_buck_active(act1), .second_scaled_buck_active(act2), .buck_boost_rail_setpoint(bb),
      .linear_regulator_rail_setpoint(lin), .pulse_skip_enable_first(ps1), .pulse_skip_enable_second(ps2),
      .transition_busy(busy), .linear_monitor_blank(blank));
   rail_host_model host (.clk(clk), .reg_rdata(rdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(addr),
      .reg_wdata(wdata), .password_unlocked(unl));
   // Free-running 50 MHz clock.
   initial begin
      clk = 1'h0;
      forever #10 clk = ~clk;
   end
   // Case-equal compare, so an unknown never passes.
   task automatic chk(input logic [7:0] g, input logic [7:0] e);
      checked++;
      if (g !== e) begin
         bad_count++;
         $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic report_and_stop;
      if (bad_count == 0 && checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Bounded wait for the transition to finish.
   task automatic wait_idle(input int n);
      for (int k = 0; k < n && busy !== 1'h0; k++) begin
         @(posedge clk);
         #1;
      end
      if (busy !== 1'h0) begin
         bad_count++;
         $display("MISMATCH t=%0t busy stuck", $time);
         report_and_stop();
      end
   endtask
   //////////////////////////////////////////////////////////////////////////////
   // Main sequence: reset, table rows, then hand-written cases.
   initial begin
      bad_count = 0;
      checked = 0;
      sys_rst = 1'h1;
      repeat (3) @(posedge clk);
      sys_rst <= 1'h0;
      host.rd(8'h1a, q);
      chk(q, 8'h06); // slew reset value.
      host.rd(8'h1b, q);
      chk(q, 8'h1f); // linear reset value.
      chk(ps1, 8'h01); // pulse-skip set at reset.
      chk(bb, 8'h32); // buck-boost reset code.
      chk(busy, 8'h00); // trigger clear at reset.
      for (int i = 0; i < 7; i++) begin
         host.wr(rows[i].a, rows[i].d, rows[i].u);
         host.rd(rows[i].a, q);
         chk(q, rows[i].e); // readback per row.
      end
      host.wr(8'h1b, 8'h10, 1'h1);
      #1 chk(blank, 8'h01); // monitor blanked.
      repeat (30) @(posedge clk);
      host.wr(8'h1b, 8'h11, 1'h0);
      #1 chk(blank, 8'h00); // refused write, no blanking.
      chk(lin, 8'h10); // locked write ignored.
      host.wr(8'h19, 8'h34, 1'h1);
      host.wr(8'h19, 8'h35, 1'h1);
      #1 chk(bb, 8'h34); // reserved code refused.
      host.wr(8'h11, 8'h08, 1'h0);
      host.wr(8'h10, 8'h0c, 1'h0);
      #1 chk(ps2, 8'h00); // pulse-skip off on second buck.
      chk(ps1, 8'h00); // pulse-skip off on first buck.
      repeat (5) @(posedge clk);
      #1 chk(act1, 8'h0a); // no apply without trigger.
      host.wr(8'h1a, 8'h86, 1'h0);
      #1 chk(busy, 8'h01); // trigger starts transition.
      repeat (188) @(posedge clk);
      #1 chk(act1, 8'h0b); // one step up.
      chk(act2, 8'h09); // one step down.
      wait_idle(400);
      chk(act1, 8'h0c); // target reached.
      chk(act2, 8'h08); // target reached.
      chk(bb, 8'h34); // buck-boost untouched.
      host.rd(8'h1a, q);
      chk(q, 8'h06); // trigger cleared itself.
      host.wr(8'h1a, 8'h47, 1'h0);
      host.wr(8'h10, 8'h0d, 1'h0);
      repeat (3) @(posedge clk);
      #1 chk(act1, 8'h0d); // auto-apply at once.
      wait_idle(10);
      host.wr(8'h1a, 8'h07, 1'h0);
      host.wr(8'h10, 8'h0a, 1'h0);
      host.wr(8'h1a, 8'h07, 1'h0);
      repeat (5) @(posedge clk);
      #1 chk(act1, 8'h0d); // writing zero changes nothing.
      host.wr(8'h1a, 8'h87, 1'h0);
      repeat (3) @(posedge clk);
      #1 chk(act1, 8'h0a); // immediate trigger.
      wait_idle(10);
      report_and_stop();
   end
endmodule
`default_nettype wire
